// ==== rtl/pwm_adv_config.sv ====
// Advanced configuration words and the multiphase output control they steer.
// Registers reached over a plain word port at their printed offsets.
`timescale 1ns/1ps
`include "pwm_adv_map.svh"
module pwm_adv_config
    import pwm_adv_pkg::*;
#(
    parameter int PHASES = 6
)
(
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                ce_in,
    // Register port
    input  wire reg_req_type         req_in,
    output logic [15:0]              rdata_out,
    // Regulator state
    input  wire reg_state_type       state_in,
    input  wire logic [2:0]          target_phases_in,
    input  wire logic [PHASES-1:0]   high_req_in,
    input  wire logic [PHASES-1:0]   over_limit_in,
    input  wire logic [11:0]         vin_live_in,
    input  wire logic                vin_latch_in,
    input  wire logic [11:0]         iout_avg_in,
    input  wire logic [11:0]         iout_inst_in,
    input  wire logic                slope_src_off_in,
    input  wire logic                first_pulse_in,
    // Outputs to power stages
    output logic [PHASES-1:0]        pwm_drive_out,
    output logic [PHASES-1:0]        pwm_oe_out,
    output logic                     pwm_mid_out,
    output logic [PHASES-1:0]        handoff_out,
    // Control outputs
    output logic [2:0]               active_phases_out,
    output logic [11:0]              vin_ton_out,
    output logic                     ontime_refresh_out,
    output logic                     protections_on_out,
    output logic                     fine_loop_en_out,
    output logic [11:0]              iout_report_out,
    output logic                     init_slope_charge_out,
    output logic [5:0]               init_slope_current_out,
    output logic                     blank_use_reg_out,
    output logic                     slope_clear_out,
    output logic                     slope_clamp_out,
    output logic                     leak_switch_open_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ps_ff;
    logic [15:0] sl_ff;
    logic [11:0] vin_held_ff;
    logic [8:0]  ini_cnt_ff;
    logic        refresh_seen_ff;
    logic [PHASES-1:0] idle;
    logic [PHASES-1:0] any_high;
    pin_level_type     lvl [PHASES];

    function automatic logic [15:0] merge(input logic [15:0] wr, input logic [15:0] ro_mask,
                                          input logic [15:0] ro_val);
        merge = (wr & ~ro_mask) | (ro_val & ro_mask);
    endfunction

    // Register writes
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            ps_ff <= `PS_RESET;
            sl_ff <= `SL_RESET;
        end
        else if (ce_in && req_in.write)
        begin
            if (req_in.addr == `PS_FORCE_OFFSET)
                ps_ff <= merge(req_in.wdata, `PS_RO_MASK, `PS_RO_VALUE);
            if (req_in.addr == `SLOPE_ADV_OFFSET)
                sl_ff <= merge(req_in.wdata, `SL_RO_MASK, 16'h0000);
        end

    // Read data, unmapped reads zero
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (ce_in)
            rdata_out <= (req_in.addr == `PS_FORCE_OFFSET) ? ps_ff :
                         (req_in.addr == `SLOPE_ADV_OFFSET) ? sl_ff : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Phase count
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            active_phases_out <= 3'(PHASES);
        else if (ce_in)
        begin
            if ((state_in.soft_start || state_in.voltage_transition) && !ps_ff[`PS_OVERRIDE_BIT])
                active_phases_out <= 3'(PHASES);
            else if (state_in.low_power_indicator)
                active_phases_out <= 3'h1;
            else
                active_phases_out <= target_phases_in;
        end

    // Held input voltage and refresh
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            vin_held_ff        <= 12'h000;
            ontime_refresh_out <= 1'b0;
            refresh_seen_ff    <= 1'b0;
            vin_ton_out        <= 12'h000;
        end
        else if (ce_in)
        begin
            if (vin_latch_in)
                vin_held_ff <= vin_live_in;
            refresh_seen_ff    <= ps_ff[`PS_REFRESH_BIT];
            ontime_refresh_out <= ps_ff[`PS_REFRESH_BIT] && refresh_seen_ff
                                  && (vin_live_in != vin_held_ff);
            vin_ton_out <= ps_ff[`PS_VIN_SRC_BIT] ? vin_held_ff : vin_live_in;
        end

    // Static control outputs
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            protections_on_out     <= 1'b1;
            fine_loop_en_out       <= 1'b0;
            iout_report_out        <= 12'h000;
            pwm_mid_out            <= 1'b0;
            blank_use_reg_out      <= 1'b0;
            slope_clear_out        <= 1'b0;
            slope_clamp_out        <= 1'b0;
            leak_switch_open_out   <= 1'b0;
            init_slope_current_out <= 6'h00;
        end
        else if (ce_in)
        begin
            protections_on_out   <= !ps_ff[`PS_PROT_DIS_BIT];
            fine_loop_en_out     <= ps_ff[`PS_FINE_BIT];
            iout_report_out      <= ps_ff[`PS_REPORT_BIT] ? iout_inst_in : iout_avg_in;
            pwm_mid_out          <= ps_ff[`PS_TRI_MODE_BIT];
            blank_use_reg_out    <= sl_ff[`SL_BLANK_SEL_BIT];
            slope_clear_out      <= state_in.dcm_exit && sl_ff[`SL_EXIT_MODE_BIT];
            slope_clamp_out      <= sl_ff[`SL_CLAMP_BIT];
            leak_switch_open_out <= sl_ff[`SL_SW_OFF_BIT] && slope_src_off_in;
            init_slope_current_out <= sl_ff[10:5];
        end

    // Initial slope charge window, capped
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            ini_cnt_ff            <= 9'h000;
            init_slope_charge_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (!state_in.soft_start || first_pulse_in || !sl_ff[`SL_INI_EN_BIT])
            begin
                init_slope_charge_out <= 1'b0;
                if (!state_in.soft_start)
                    ini_cnt_ff <= 9'h000;
            end
            else if (ini_cnt_ff < 9'(`INI_MAX_CYC))
            begin
                init_slope_charge_out <= 1'b1;
                ini_cnt_ff            <= ini_cnt_ff + 9'h001;
            end
            else
                init_slope_charge_out <= 1'b0;
        end

    ////////////////////////////////////////////////////////////////////////
    // Phase output stages
    assign any_high = high_req_in & ~idle;

    generate
        for (genvar i = 0; i < PHASES; i++)
        begin : g_phase
            assign idle[i] = (3'(i) >= active_phases_out);
            pwm_phase_gate u_gate (
                .clk_in            (clk_in),
                .rst_in            (rst_in),
                .ce_in             (ce_in),
                .tri_delay_in      (ps_ff[4:0]),
                .oc_code_in        (sl_ff[13:12]),
                .limit_active_in   (!state_in.soft_start || sl_ff[`SL_VALLEY_BIT]),
                .pre_bias_in       (sl_ff[`SL_PRE_BIAS_BIT]),
                .high_req_in       (high_req_in[i]),
                .over_limit_in     (over_limit_in[i]),
                .any_first_high_in (|any_high),
                .idle_in           (idle[i]),
                .handoff_out       (handoff_out[i]),
                .level_out         (lvl[i])
            );
            assign pwm_drive_out[i] = (lvl[i] == PIN_HIGH);
            // Mid level is driven only in forced mid mode
            assign pwm_oe_out[i] = (lvl[i] != PIN_MID) || pwm_mid_out;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    a_ps_reserved_read: assert property (@(posedge clk_in) disable iff (rst_in)
        (ps_ff & `PS_RO_MASK) == `PS_RO_VALUE) else $error("reserved bits wrong");
    a_sl_top_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        sl_ff[15] == 1'b0) else $error("slope top bit set");
    a_prot_follow: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in |=> protections_on_out == !$past(ps_ff[`PS_PROT_DIS_BIT]))
        else $error("protection gate wrong");
    a_full_phase_ss: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && state_in.soft_start && !ps_ff[15] |=> active_phases_out == 3'(PHASES))
        else $error("not full phase");
    a_vin_source: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && ps_ff[12] |=> vin_ton_out == $past(vin_held_ff))
        else $error("vin source wrong");
    a_fine_loop: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in |=> fine_loop_en_out == $past(ps_ff[7])) else $error("fine loop wrong");
    a_report_mode: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !ps_ff[5] |=> iout_report_out == $past(iout_avg_in))
        else $error("report mode wrong");
    a_ini_cap: assert property (@(posedge clk_in) disable iff (rst_in)
        ini_cnt_ff <= 9'(`INI_MAX_CYC)) else $error("charge too long");
    a_leak_switch: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !sl_ff[0] |=> !leak_switch_open_out) else $error("switch opened");
    a_refresh_off: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && !ps_ff[8] |=> !ontime_refresh_out) else $error("refresh while off");

    c_handoff: cover property (@(posedge clk_in) disable iff (rst_in) |handoff_out);
    c_charge: cover property (@(posedge clk_in) disable iff (rst_in) init_slope_charge_out);
    c_refresh: cover property (@(posedge clk_in) disable iff (rst_in) ontime_refresh_out);
    c_mid: cover property (@(posedge clk_in) disable iff (rst_in) pwm_mid_out && |idle);
endmodule

// ==== rtl/pwm_adv_map.svh ====
// Offsets, field positions, reset values and timing counts of the
// advanced PWM configuration words. Included by bare name; no logic.
`ifndef PWM_ADV_MAP_SVH
`define PWM_ADV_MAP_SVH

`define PS_FORCE_OFFSET     8'h3b
`define SLOPE_ADV_OFFSET    8'h3d

`define PS_OVERRIDE_BIT     15
`define PS_TRI_MODE_BIT     14
`define PS_VIN_SRC_BIT      12
`define PS_PROT_DIS_BIT     11
`define PS_REFRESH_BIT      8
`define PS_FINE_BIT         7
`define PS_REPORT_BIT       5
`define PS_RO_MASK          16'h2640
`define PS_RO_VALUE         16'h0640
`define PS_RESET            16'h0640

`define SL_VALLEY_BIT       14
`define SL_INI_EN_BIT       11
`define SL_BLANK_SEL_BIT    4
`define SL_PRE_BIAS_BIT     3
`define SL_EXIT_MODE_BIT    2
`define SL_CLAMP_BIT        1
`define SL_SW_OFF_BIT       0
`define SL_RO_MASK          16'h8000
`define SL_RESET            16'h0000

`define CLK_PERIOD_PS       8000
`define TRI_STEP_PS         5000
`define OC_STEP_PS          20000
`define OC_BASE_PS          15000
`define INI_MAX_PS          400000
// Whole cycles: a least time rounds up, the charge limit rounds down
`define TRI_STEP_CYC  ((`TRI_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OC_STEP_CYC   ((`OC_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OC_BASE_CYC   ((`OC_BASE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define INI_MAX_CYC   (`INI_MAX_PS / `CLK_PERIOD_PS)

`endif

// ==== rtl/pwm_adv_pkg.sv ====
// Types shared by the advanced PWM configuration logic.
// Assumes the map header for all numeric constants.
package pwm_adv_pkg;

    typedef enum logic [1:0] {PIN_LOW, PIN_HIGH, PIN_MID} pin_level_type;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic soft_start;
        logic voltage_transition;
        logic low_power_indicator;
        logic dcm_exit;
    } reg_state_type;

endpackage

// ==== rtl/pwm_phase_gate.sv ====
// One phase's output stage: valley hold-off with hand-off, low insert
// before mid level, and idle exit. Assumes a single clock domain.
`timescale 1ns/1ps
`include "pwm_adv_map.svh"
module pwm_phase_gate
    import pwm_adv_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    input  wire logic            ce_in,
    // Configuration
    input  wire logic [4:0]      tri_delay_in,
    input  wire logic [1:0]      oc_code_in,
    input  wire logic            limit_active_in,
    input  wire logic            pre_bias_in,
    // Phase control
    input  wire logic            high_req_in,
    input  wire logic            over_limit_in,
    input  wire logic            any_first_high_in,
    input  wire logic            idle_in,
    // Results
    output logic                 handoff_out,
    output pin_level_type        level_out
);
    logic [7:0] wait_ff;
    logic [7:0] low_ff;
    logic       idle_ff;
    logic [7:0] oc_limit;
    logic       hold;

    assign oc_limit = 8'(`OC_BASE_CYC + `OC_STEP_CYC * oc_code_in);
    assign hold     = high_req_in && over_limit_in && limit_active_in;

    // Hold-off counter
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            wait_ff     <= 8'h00;
            handoff_out <= 1'b0;
        end
        else if (ce_in)
        begin
            handoff_out <= 1'b0;
            if (!hold)
                wait_ff <= 8'h00;
            else if (wait_ff + 8'h01 >= oc_limit)
            begin
                wait_ff     <= 8'h00;
                handoff_out <= 1'b1;
            end
            else
                wait_ff <= wait_ff + 8'h01;
        end

    // Idle state and low insert
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
        begin
            level_out <= PIN_MID;
            low_ff    <= 8'h00;
            idle_ff   <= 1'b1;
        end
        else if (ce_in)
        begin
            if (idle_in && !idle_ff)
            begin
                idle_ff <= 1'b1;
                if (level_out == PIN_HIGH)
                begin
                    level_out <= PIN_LOW;
                    low_ff    <= 8'(tri_delay_in * `TRI_STEP_CYC);
                end
                else
                    level_out <= PIN_MID;
            end
            else if (idle_ff)
            begin
                if (low_ff != 8'h00)
                    low_ff <= low_ff - 8'h01;
                else if (level_out == PIN_LOW && !pre_bias_in)
                    level_out <= PIN_MID;
                if (!idle_in && high_req_in && !hold)
                begin
                    idle_ff   <= 1'b0;
                    level_out <= PIN_HIGH;
                end
                else if (!idle_in && pre_bias_in && any_first_high_in && low_ff == 8'h00)
                begin
                    idle_ff   <= 1'b0;
                    level_out <= PIN_LOW;
                end
            end
            else
                level_out <= (high_req_in && !hold) ? PIN_HIGH : PIN_LOW;
        end
endmodule

// ==== dv/pwm_stage_model.sv ====
// Power-stage model on the PWM pins: turns each pin into a sampled level.
// Assumes one driver per pin from the block; an undriven pin floats to mid.
`timescale 1ns/1ps
module pwm_stage_model
    import pwm_adv_pkg::*;
#(
    parameter int PHASES = 6
)
(
    // Clock
    input  wire logic              clk_in,
    // Pins from the block
    input  wire logic [PHASES-1:0] drive_in,
    input  wire logic [PHASES-1:0] oe_in,
    input  wire logic              mid_in,
    // Sampled stage level
    output pin_level_type          level_out [PHASES]
);
    ////////////////////////////////////////////////////////////////////////////
    // Driven low is sampled as low whether or not mid_in is set
    always_ff @(posedge clk_in)
    begin
        for (int i = 0; i < PHASES; i++)
        begin
            if (!oe_in[i])
                level_out[i] <= PIN_MID;
            else if (drive_in[i])
                level_out[i] <= PIN_HIGH;
            else
                level_out[i] <= PIN_LOW;
        end
    end
endmodule

// ==== dv/multiphase_pwm_advanced_config_bench.sv ====
// Bench for the advanced PWM configuration block: register words and the
// controls they steer, against an integer model. Assumes the stage model.
`timescale 1ns/1ps
module multiphase_pwm_advanced_config_bench;
    import pwm_adv_pkg::*;
    logic          clk_in = 1'b0;
    logic          rst_in = 1'b1;
    logic          ce_in = 1'b1;
    reg_req_type   req = '0;
    reg_state_type st = '0;
    logic [2:0]    tgt = 3'h6;
    logic [5:0]    hreq = '0;
    logic [5:0]    ovl = '0;
    logic [11:0]   vlive = '0;
    logic          vlatch = 1'b0;
    logic [11:0]   iavg = '0;
    logic [11:0]   iinst = '0;
    logic          soff = 1'b0;
    logic          fpulse = 1'b0;
    logic [15:0]   rdata;
    logic [5:0]    drv, oe, hand, icur;
    logic          mid, refresh, prot, fine, charge, blank, sclr, clamp, leak;
    logic [2:0]    act;
    logic [11:0]   vton, irep;
    pin_level_type lvl [6];
    int            error_cnt = 0;
    int            checks_done = 0;
    int            ps_m = 'h0640;
    int            sl_m = 0;
    int            held, cnt, d;

    always #4 clk_in = ~clk_in;

    pwm_adv_config #(.PHASES(6)) pwm_adv_config_inst (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(ce_in), .req_in(req), .rdata_out(rdata), .state_in(st),
        .target_phases_in(tgt), .high_req_in(hreq), .over_limit_in(ovl),
        .vin_live_in(vlive), .vin_latch_in(vlatch), .iout_avg_in(iavg),
        .iout_inst_in(iinst), .slope_src_off_in(soff), .first_pulse_in(fpulse),
        .pwm_drive_out(drv), .pwm_oe_out(oe), .pwm_mid_out(mid), .handoff_out(hand),
        .active_phases_out(act), .vin_ton_out(vton), .ontime_refresh_out(refresh),
        .protections_on_out(prot), .fine_loop_en_out(fine), .iout_report_out(irep),
        .init_slope_charge_out(charge), .init_slope_current_out(icur),
        .blank_use_reg_out(blank), .slope_clear_out(sclr), .slope_clamp_out(clamp),
        .leak_switch_open_out(leak));

    pwm_stage_model #(.PHASES(6)) pwm_stage_model_inst (.clk_in(clk_in), .drive_in(drv),
        .oe_in(oe), .mid_in(mid), .level_out(lvl));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Host changes the words only between transitions
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        req = '{1'b1, a, v};
        tick(1);
        req.write = 1'b0;
        if (a == 8'h3b) ps_m = (v & 'hd9bf) | 'h0640;
        if (a == 8'h3d) sl_m = v & 'h7fff;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        req.addr = a;
        tick(1);
        chk("rdata", exp, rdata);
    endtask

    task automatic cfg_check();
        chk("prot", 16'(!ps_m[11]), 16'(prot));
        chk("fine", 16'(ps_m[7]), 16'(fine));
        chk("mid", 16'(ps_m[14]), 16'(mid));
        chk("irep", 16'(ps_m[5] ? iinst : iavg), 16'(irep));
        chk("vton", 16'(ps_m[12] ? held : vlive), 16'(vton));
        chk("blank", 16'(sl_m[4]), 16'(blank));
        chk("clamp", 16'(sl_m[1]), 16'(clamp));
        chk("icur", 16'(sl_m[10:5]), 16'(icur));
        chk("leak", 16'(sl_m[0] && soff), 16'(leak));
        chk("sclr", 16'(sl_m[2] && st.dcm_exit), 16'(sclr));
    endtask

    task automatic oc_try(output int n);
        hreq[0] = 1'b1;
        ovl[0] = 1'b1;
        n = 0;
        while (hand[0] !== 1'b1 && n < 30)
        begin
            tick(1);
            n++;
        end
        hreq[0] = 1'b0;
        ovl[0] = 1'b0;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        void'($urandom(27957));
        tick(10);
        rst_in = 1'b0;
        tick(1);
        rd(8'h3b, 16'h0640);
        rd(8'h3d, 16'h0000);
        rd(8'h3e, 16'h0000);
        chk("prot_rst", 16'h0001, 16'(prot));
        iavg = 12'($urandom);
        iinst = 12'($urandom);
        vlive = 12'($urandom);
        vlatch = 1'b1;
        tick(1);
        vlatch = 1'b0;
        held = vlive;
        vlive = ~vlive;
        for (int i = 0; i < 12; i++)
        begin
            wr(8'h3b, 16'($urandom));
            wr(8'h3d, 16'($urandom));
            wr(8'h3c, 16'($urandom));
            soff = 1'($urandom);
            st.dcm_exit = 1'($urandom);
            tick(2);
            rd(8'h3b, 16'(ps_m));
            rd(8'h3d, 16'(sl_m));
            cfg_check();
        end
        wr(8'h3b, 16'(ps_m | 'h0100));
        tick(3);
        chk("refresh_on", 16'h0001, 16'(refresh));
        vlive = 12'(held);
        tick(3);
        chk("refresh_same", 16'h0000, 16'(refresh));
        vlive = ~vlive;
        wr(8'h3b, 16'(ps_m & 'hfeff));
        tick(3);
        chk("refresh_off", 16'h0000, 16'(refresh));
        st.soft_start = 1'b1;
        st.low_power_indicator = 1'b1;
        wr(8'h3b, 16'(ps_m & 'h7fff));
        tick(3);
        chk("phases_full", 16'h0006, 16'(act));
        wr(8'h3b, 16'(ps_m | 'h8000));
        tick(3);
        chk("phases_low", 16'h0001, 16'(act));
        wr(8'h3d, 16'h0800 | 16'($urandom & 'h07e0));
        cnt = 0;
        repeat (70)
        begin
            tick(1);
            cnt += int'(charge === 1'b1);
        end
        chk("ini_len", 16'h0001, 16'(cnt >= 1 && cnt <= 50));
        wr(8'h3d, 16'h0000);
        oc_try(cnt);
        chk("ss_nolimit", 16'd30, 16'(cnt));
        wr(8'h3d, 16'h4000);
        oc_try(cnt);
        chk("ss_limit", 16'h0001, 16'(cnt < 30));
        st.soft_start = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h3d, 16'(c << 12));
            oc_try(cnt);
            chk("handoff", 16'h0001, 16'(cnt >= 2 + 3 * c && cnt <= 4 + 3 * c));
        end
        st.soft_start = 1'b1;
        st.low_power_indicator = 1'b0;
        d = 1 + int'($urandom % 20);
        wr(8'h3b, 16'((ps_m & 'h3fe0) | 'h8000 | d));
        hreq[5] = 1'b1;
        tick(3);
        // Phase 5 is shed while still high, so it goes low for the insert time, then to mid
        st.low_power_indicator = 1'b1;
        cnt = 0;
        repeat (40)
        begin
            tick(1);
            cnt += int'(lvl[5] == PIN_LOW);
        end
        hreq[5] = 1'b0;
        chk("low_insert", 16'h0001, 16'(cnt >= d && cnt <= d + 2));
        chk("idle_hiz", 16'h0000, 16'(oe[5]));
        // Adding phases in pre-bias mode: idle phase drops low on any high
        wr(8'h3d, 16'h0008);
        st.low_power_indicator = 1'b0;
        hreq[0] = 1'b1;
        tick(4);
        chk("pre_bias", 16'(PIN_LOW), 16'(lvl[5]));
        hreq[0] = 1'b0;
        // Clock enable low: a write must not land
        ce_in = 1'b0;
        req = '{1'b1, 8'h3b, 16'(~ps_m)};
        tick(2);
        req.write = 1'b0;
        ce_in = 1'b1;
        rd(8'h3b, 16'(ps_m));
        end_sim();
    end
endmodule
